//--- rtl/isl_pkg.sv
// package: constants shared by the i2c slave and its bus master
package isl_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_HALF_CYC = (SCL_PERIOD_NS * (CLK_HZ / 1000000)) / 2000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_ADDR2 = 8'h0C;
  localparam logic [7:0] OFS_RXBUF = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_MSTAT = 8'h18;
  localparam logic [7:0] OFS_MRX = 8'h1C;
  localparam int CTL_MODE = 0;
  localparam int CTL_ADDRESS_HOLD_ENABLE = 2;
  localparam int CTL_DATA_HOLD_ENABLE = 3;
  localparam int CTL_ACK_RESPONSE_VALUE = 4;
  localparam int CTL_BUFFER_OVERWRITE_ENABLE = 5;
  localparam int CTL_SEN = 6;
  localparam int CTL_CKP = 7;
  localparam int CTL_START_IRQ_ENABLE = 8;
  localparam int CTL_PCIE = 9;
  localparam int ST_BF = 0;
  localparam int ST_OV = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_UA = 3;
  localparam int ST_ACK_TIME_FLAG = 4;
  localparam int ST_ACK_RESULT_FLAG = 5;
  localparam int ST_START = 6;
  localparam int ST_STOP = 7;
  localparam int ST_RW = 8;
  localparam int ST_DA = 9;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_WRITE = 2;
  localparam int CMD_READ = 3;
  localparam int CMD_NACK = 4;
  localparam int CMD_DATA = 8;
  localparam logic [1:0] MODE_7 = 2'h0;
  localparam logic [1:0] MODE_10 = 2'h1;
  localparam logic [1:0] MODE_7_SP = 2'h2;
  localparam logic [1:0] MODE_10_SP = 2'h3;
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [6:0] RST_ADDR = 7'h00;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
endpackage

//--- rtl/isl_bus_if.sv
// interface: open-drain i2c bus joining slave and master
`timescale 1ns/10ps
interface isl_bus_if;
  logic scl_o_dev;
  logic scl_oe_dev;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled low driver wins
  assign scl = !((scl_oe_dev && !scl_o_dev) || (scl_oe_host && !scl_o_host));
  assign sda = !((sda_oe_dev && !sda_o_dev) || (sda_oe_host && !sda_o_host));
  modport dev (input scl, input sda, output scl_o_dev, output scl_oe_dev, output sda_o_dev, output sda_oe_dev);
  modport host (input scl, input sda, output scl_o_host, output scl_oe_host, output sda_o_host, output sda_oe_host);
endinterface

//--- rtl/isl_slave.sv
// i2c slave receiver with 7/10-bit matching, ack control and stretching
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module isl_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  isl_bus_if.dev bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {ISL_IDLE, ISL_ADDR, ISL_ACK, ISL_DATA, ISL_WAIT, ISL_SKIP} isl_state_t;
  isl_state_t st_r;
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_q_r, sda_q_r;
  logic [9:0] ctrl_r;
  logic [9:0] stat_r;
  logic [7:0] addr_r;
  logic [6:0] addr2_r;
  logic [7:0] rxbuf_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic first_r, hi_r, prior_r, ack_r, hold_r, rd_r, lo_r;
  logic scl_rise, scl_fall, start_det, stop_det, sp_irq;
  logic aw_done_r, w_done_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_go, rd_go;
  logic [7:0] rd_addr;

  // rule-of-thumb match for the first byte of a transfer
  function automatic logic match7(input logic [7:0] b, input logic [7:0] a, input logic [6:0] a2);
    match7 = (b[7:1] == a[7:1]) || (b[7:1] == a2);
  endfunction

  // two flops before anything looks at the pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else if (aclk_en)
    begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      scl_q_r <= scl_s_r[1];
      sda_q_r <= sda_s_r[1];
    end
  end
  assign scl_rise = scl_s_r[1] && !scl_q_r;
  assign scl_fall = !scl_s_r[1] && scl_q_r;
  assign start_det = scl_s_r[1] && scl_q_r && sda_q_r && !sda_s_r[1];
  assign stop_det = scl_s_r[1] && scl_q_r && !sda_q_r && sda_s_r[1];
  assign sp_irq = ctrl_r[isl_pkg::CTL_MODE+1] || (ctrl_r[isl_pkg::CTL_START_IRQ_ENABLE] && start_det)
                  || (ctrl_r[isl_pkg::CTL_PCIE] && stop_det);

  // axi4-lite: address and data may arrive in any order
  assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
  assign s_axi_wready = !w_done_r && !s_axi_bvalid;
  assign wr_go = aw_done_r && w_done_r && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign rd_addr = s_axi_araddr;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_done_r <= 1'b0;
      w_done_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end
    else if (aclk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_done_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        aw_done_r <= 1'b0;
        w_done_r <= 1'b0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        case (rd_addr)
          isl_pkg::OFS_CTRL: s_axi_rdata <= {22'h0, ctrl_r};
          isl_pkg::OFS_STAT: s_axi_rdata <= {22'h0, stat_r};
          isl_pkg::OFS_ADDR: s_axi_rdata <= {24'h0, addr_r};
          isl_pkg::OFS_ADDR2: s_axi_rdata <= {24'h0, addr2_r, 1'b0};
          isl_pkg::OFS_RXBUF: s_axi_rdata <= {24'h0, rxbuf_r};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // protocol engine and status; hardware sets win over software clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ISL_IDLE;
      ctrl_r <= isl_pkg::RST_CTRL[9:0];
      stat_r <= 10'h000;
      addr_r <= {isl_pkg::RST_ADDR, 1'b0};
      addr2_r <= isl_pkg::RST_ADDR;
      rxbuf_r <= 8'h00;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      first_r <= 1'b0;
      hi_r <= 1'b0;
      prior_r <= 1'b0;
      ack_r <= 1'b0;
      hold_r <= 1'b0;
      rd_r <= 1'b0;
      lo_r <= 1'b0;
    end
    else if (aclk_en)
    begin
      if (wr_go)
      begin
        case (awaddr_r)
          isl_pkg::OFS_CTRL:
          begin
            if (s_axi_wstrb[0])
              ctrl_r[7:0] <= wdata_r[7:0];
            if (s_axi_wstrb[1])
              ctrl_r[9:8] <= wdata_r[9:8];
          end
          isl_pkg::OFS_STAT:
            if (s_axi_wstrb[0])
              stat_r[7:0] <= stat_r[7:0] & ~wdata_r[7:0];
          isl_pkg::OFS_ADDR:
            if (s_axi_wstrb[0])
            begin
              addr_r <= wdata_r[7:0];
              stat_r[isl_pkg::ST_UA] <= 1'b0;
              hold_r <= 1'b0;
            end
          isl_pkg::OFS_ADDR2:
            if (s_axi_wstrb[0])
              addr2_r <= wdata_r[7:1];
          default: ;
        endcase
      end
      if (rd_go && rd_addr == isl_pkg::OFS_RXBUF)
        stat_r[isl_pkg::ST_BF] <= 1'b0;
      if (start_det)
      begin
        st_r <= ISL_ADDR;
        bit_r <= 4'h0;
        first_r <= 1'b1;
        hi_r <= 1'b0;
        hold_r <= 1'b0;
        lo_r <= 1'b0;
        stat_r[isl_pkg::ST_START] <= 1'b1;
        stat_r[isl_pkg::ST_STOP] <= 1'b0;
        if (sp_irq)
          stat_r[isl_pkg::ST_IRQ] <= 1'b1;
      end
      else if (stop_det)
      begin
        st_r <= ISL_IDLE;
        prior_r <= 1'b0;
        hold_r <= 1'b0;
        stat_r[isl_pkg::ST_STOP] <= 1'b1;
        stat_r[isl_pkg::ST_START] <= 1'b0;
        if (sp_irq)
          stat_r[isl_pkg::ST_IRQ] <= 1'b1;
      end
      else
      begin
        case (st_r)
          ISL_IDLE, ISL_SKIP: ;
          ISL_ADDR, ISL_DATA:
          begin
            if (scl_rise)
            begin
              sh_r <= {sh_r[6:0], sda_q_r};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8)
            begin
              // eighth fall: decide acceptance of the byte
              logic ok;
              logic full;
              ok = 1'b1;
              full = stat_r[isl_pkg::ST_BF] || stat_r[isl_pkg::ST_OV];
              if (st_r == ISL_ADDR && first_r)
              begin
                if (ctrl_r[isl_pkg::CTL_MODE])
                begin
                  ok = (sh_r[7:3] == isl_pkg::TEN_BIT_HDR) && (sh_r[2:1] == addr_r[2:1]);
                  if (sh_r[0] && !prior_r)
                    ok = 1'b0;
                  if (!sh_r[0] && !ok)
                    prior_r <= 1'b0;
                end
                else
                  ok = match7(sh_r, addr_r, addr2_r);
                rd_r <= sh_r[0];
                stat_r[isl_pkg::ST_RW] <= sh_r[0];
              end
              else if (st_r == ISL_ADDR)
              begin
                // low byte is always accepted; a miss only leaves prior clear
                ok = 1'b1;
                prior_r <= (sh_r == addr_r);
                lo_r <= 1'b1;
              end
              if (!ok)
                st_r <= ISL_SKIP;
              else
              begin
                if (full && !ctrl_r[isl_pkg::CTL_BUFFER_OVERWRITE_ENABLE])
                begin
                  ack_r <= 1'b0;
                  if (stat_r[isl_pkg::ST_BF] && st_r == ISL_DATA)
                    stat_r[isl_pkg::ST_OV] <= 1'b1;
                end
                else
                begin
                  rxbuf_r <= sh_r;
                  stat_r[isl_pkg::ST_BF] <= 1'b1;
                  if (ctrl_r[isl_pkg::CTL_ADDRESS_HOLD_ENABLE] && ctrl_r[isl_pkg::CTL_DATA_HOLD_ENABLE])
                    ack_r <= !ctrl_r[isl_pkg::CTL_ACK_RESPONSE_VALUE];
                  else
                    ack_r <= 1'b1;
                end
                stat_r[isl_pkg::ST_DA] <= (st_r == ISL_DATA);
                if (ctrl_r[isl_pkg::CTL_ADDRESS_HOLD_ENABLE] || ctrl_r[isl_pkg::CTL_DATA_HOLD_ENABLE])
                  stat_r[isl_pkg::ST_ACK_TIME_FLAG] <= 1'b1;
                stat_r[isl_pkg::ST_IRQ] <= 1'b1;
                // both 10-bit address bytes end in an update-address wait
                hi_r <= (first_r && ctrl_r[isl_pkg::CTL_MODE] && !sh_r[0]) || (st_r == ISL_ADDR && !first_r);
                st_r <= ISL_ACK;
              end
              first_r <= 1'b0;
              bit_r <= 4'h0;
            end
          end
          ISL_ACK:
          begin
            if (scl_rise)
              stat_r[isl_pkg::ST_ACK_RESULT_FLAG] <= sda_q_r;
            if (scl_fall)
            begin
              stat_r[isl_pkg::ST_ACK_TIME_FLAG] <= 1'b0;
              if (!ack_r)
                st_r <= ISL_SKIP;
              else if (hi_r)
              begin
                stat_r[isl_pkg::ST_UA] <= 1'b1;
                stat_r[isl_pkg::ST_IRQ] <= 1'b1;
                hold_r <= 1'b1;
                hi_r <= 1'b0;
                st_r <= ISL_WAIT;
              end
              else if (rd_r)
                st_r <= ISL_SKIP;
              else
              begin
                if (ctrl_r[isl_pkg::CTL_SEN])
                begin
                  ctrl_r[isl_pkg::CTL_CKP] <= 1'b0;
                  hold_r <= 1'b1;
                end
                st_r <= ctrl_r[isl_pkg::CTL_SEN] ? ISL_WAIT : ISL_DATA;
              end
            end
          end
          ISL_WAIT:
          begin
            if (!stat_r[isl_pkg::ST_UA] && !hold_r)
            begin
              // after the low byte only a full match goes on to data
              lo_r <= 1'b0;
              st_r <= lo_r ? (prior_r ? ISL_DATA : ISL_SKIP) : ISL_ADDR;
            end
            else if (ctrl_r[isl_pkg::CTL_SEN] && !stat_r[isl_pkg::ST_UA] && ctrl_r[isl_pkg::CTL_CKP])
            begin
              hold_r <= 1'b0;
              st_r <= ISL_DATA;
            end
          end
          default: st_r <= ISL_IDLE;
        endcase
      end
    end
  end

  // open-drain outputs: drive low only; ack on the ninth pulse, hold scl while waiting
  assign bus.sda_o_dev = 1'b0;
  assign bus.sda_oe_dev = (st_r == ISL_ACK) && ack_r;
  assign bus.scl_o_dev = 1'b0;
  assign bus.scl_oe_dev = (st_r == ISL_WAIT) && hold_r;
  // mode field values documented in package, 2 bits
endmodule // isl_slave

//--- rtl/isl_master.sv
// i2c bus master driving the slave, commanded over axi4-lite
`timescale 1ns/10ps
module isl_master (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  isl_bus_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {ISM_IDLE, ISM_START, ISM_BIT, ISM_STOP} ism_state_t;
  ism_state_t st_r;
  logic [1:0] scl_s_r, sda_s_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic [7:0] rx_r;
  logic ack_result_flag_r, phase_r, scl_drv_r, sda_drv_r;
  logic aw_done_r, w_done_r;
  logic [31:0] wdata_r;
  logic go;
  assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
  assign s_axi_wready = !w_done_r && !s_axi_bvalid;
  assign go = aw_done_r && w_done_r && !s_axi_bvalid && st_r == ISM_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end
    else if (aclk_en)
    begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_done_r <= 1'b0;
      w_done_r <= 1'b0;
      wdata_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end
    else if (aclk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_done_r <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (go)
      begin
        s_axi_bvalid <= 1'b1;
        aw_done_r <= 1'b0;
        w_done_r <= 1'b0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= (s_axi_araddr == isl_pkg::OFS_MRX) ? {24'h0, rx_r} :
                       {30'h0, ack_result_flag_r, st_r != ISM_IDLE};
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // bit engine; waits while the slave stretches scl
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ISM_IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 9'h1FF;
      rx_r <= 8'h00;
      ack_result_flag_r <= 1'b0;
      phase_r <= 1'b0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end
    else if (aclk_en)
    begin
      case (st_r)
        ISM_IDLE:
          if (go)
          begin
            cnt_r <= 16'h0000;
            phase_r <= 1'b0;
            bit_r <= 4'h0;
            sh_r <= {wdata_r[isl_pkg::CMD_DATA +: 8], !wdata_r[isl_pkg::CMD_NACK]};
            if (wdata_r[isl_pkg::CMD_READ])
              sh_r <= {8'hFF, !wdata_r[isl_pkg::CMD_NACK]};
            if (wdata_r[isl_pkg::CMD_START])
              st_r <= ISM_START;
            else if (wdata_r[isl_pkg::CMD_STOP])
              st_r <= ISM_STOP;
            else if (wdata_r[isl_pkg::CMD_WRITE] || wdata_r[isl_pkg::CMD_READ])
              st_r <= ISM_BIT;
          end
        ISM_START, ISM_STOP:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(isl_pkg::SCL_HALF_CYC))
          begin
            // scl stays released so the sda edge is seen with scl high
            sda_drv_r <= (st_r == ISM_START);
            scl_drv_r <= 1'b0;
          end
          else if (cnt_r == 16'(2 * isl_pkg::SCL_HALF_CYC))
          begin
            scl_drv_r <= (st_r == ISM_START);
            st_r <= ISM_IDLE;
          end
          else if (cnt_r == 16'h0000)
          begin
            sda_drv_r <= (st_r == ISM_STOP);
            scl_drv_r <= (st_r == ISM_START) ? scl_drv_r : 1'b1;
          end
          else if (st_r == ISM_STOP && cnt_r == 16'(isl_pkg::SCL_HALF_CYC / 2))
            scl_drv_r <= 1'b0;
        end
        ISM_BIT:
        begin
          if (!phase_r)
          begin
            sda_drv_r <= !sh_r[8];
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == 16'(isl_pkg::SCL_HALF_CYC))
            begin
              scl_drv_r <= 1'b0;
              phase_r <= 1'b1;
              cnt_r <= 16'h0000;
            end
          end
          else if (scl_s_r[1])
          begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == 16'h0000)
              sh_r <= {sh_r[7:0], sda_s_r[1]};
            if (cnt_r == 16'(isl_pkg::SCL_HALF_CYC))
            begin
              scl_drv_r <= 1'b1;
              phase_r <= 1'b0;
              cnt_r <= 16'h0000;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8)
              begin
                ack_result_flag_r <= sh_r[0];
                rx_r <= sh_r[8:1];
                st_r <= ISM_IDLE;
              end
            end
          end
        end
        default: st_r <= ISM_IDLE;
      endcase
    end
  end
  assign bus.scl_o_host = 1'b0;
  assign bus.scl_oe_host = scl_drv_r;
  assign bus.sda_o_host = 1'b0;
  assign bus.sda_oe_host = sda_drv_r;
endmodule // isl_master

//--- sim/isl_asserts.sv
// checker: wire-level rules of the i2c link
`timescale 1ns/10ps
module isl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_dev,
  input wire logic sda_oe_dev,
  input wire logic sda_oe_host
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ack_raise_low_a: assert property ($rose(sda_oe_dev) |-> !scl) else $error("ack raised with scl high");
  ack_drop_low_a: assert property ($fell(sda_oe_dev) |-> !scl) else $error("ack dropped with scl high");
  ack_wire_low_a: assert property (sda_oe_dev |-> !sda) else $error("ack not seen on sda");
  ack_min_len_a: assert property ($rose(sda_oe_dev) |-> sda_oe_dev[*8]) else $error("ack too short");
  ack_over_high_a: assert property ($rose(scl) && sda_oe_dev |=> sda_oe_dev[*8]) else $error("ack left in high");
  host_sda_free_a: assert property ($rose(scl) && sda_oe_dev |-> !sda_oe_host) else $error("master holds sda");
  stretch_low_a: assert property ($rose(scl_oe_dev) |-> !scl) else $error("stretch began with scl high");
  stretch_hold_a: assert property ($rose(scl_oe_dev) |=> scl_oe_dev[*8]) else $error("stretch too short");
endmodule // isl_asserts

//--- sim/i2c_slave_addr_ack_receive_tb_top.sv
// testbench: two axi masters drive the slave and its bus master
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module i2c_slave_addr_ack_receive_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr [2] = '{8'h00, 8'h00};
  logic [7:0] araddr [2] = '{8'h00, 8'h00};
  logic [31:0] wdata [2] = '{32'h0, 32'h0};
  logic [1:0] awvalid = 2'h0, wvalid = 2'h0, bready = 2'h0, arvalid = 2'h0, rready = 2'h0;
  wire [1:0] awready, wready, bvalid, arready, rvalid;
  wire [31:0] rdata [2];
  logic [31:0] sq, mq;
  logic [7:0] adr [3] = '{8'h55, 8'h45, 8'h60};
  int mismatches = 0;
  int checks = 0;
  isl_bus_if bus ();
  isl_slave i_isl_slave (.aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1), .bus(bus.dev), .s_axi_awaddr(awaddr[0]),
    .s_axi_awvalid(awvalid[0]), .s_axi_awready(awready[0]), .s_axi_wdata(wdata[0]), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid[0]), .s_axi_wready(wready[0]), .s_axi_bresp(), .s_axi_bvalid(bvalid[0]),
    .s_axi_bready(bready[0]), .s_axi_araddr(araddr[0]), .s_axi_arvalid(arvalid[0]), .s_axi_arready(arready[0]),
    .s_axi_rdata(rdata[0]), .s_axi_rresp(), .s_axi_rvalid(rvalid[0]), .s_axi_rready(rready[0]));
  isl_master i_isl_master (.aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1), .bus(bus.host), .s_axi_awaddr(awaddr[1]),
    .s_axi_awvalid(awvalid[1]), .s_axi_awready(awready[1]), .s_axi_wdata(wdata[1]), .s_axi_wvalid(wvalid[1]),
    .s_axi_wready(wready[1]), .s_axi_bvalid(bvalid[1]), .s_axi_bready(bready[1]), .s_axi_araddr(araddr[1]),
    .s_axi_arvalid(arvalid[1]), .s_axi_arready(arready[1]), .s_axi_rdata(rdata[1]), .s_axi_rvalid(rvalid[1]),
    .s_axi_rready(rready[1]));
  isl_asserts i_isl_asserts (.aclk(aclk), .aresetn(aresetn), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_dev(bus.scl_oe_dev), .sda_oe_dev(bus.sda_oe_dev), .sda_oe_host(bus.sda_oe_host));
  always #10 aclk = ~aclk;
  // readies are combinational: sample mid-cycle, act at the next rising edge
  task automatic xfer(input int m, input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic [4:0] p;
    logic [4:0] k;
    @(posedge aclk);
    awaddr[m] <= a;
    araddr[m] <= a;
    wdata[m] <= d;
    p = w ? 5'h07 : 5'h18;
    while (p != 5'h00)
    begin
      {rready[m], arvalid[m], bready[m], wvalid[m], awvalid[m]} <= p;
      @(negedge aclk);
      k = p & {rvalid[m], arready[m], bvalid[m], wready[m], awready[m]};
      if (k[4])
        r = rdata[m];
      @(posedge aclk);
      p = p & ~k;
    end
    {rready[m], arvalid[m], bready[m], wvalid[m], awvalid[m]} <= 5'h00;
  endtask
  task automatic sw(input int m, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(m, 1'b1, a, d, x);
  endtask
  task automatic st(input logic [7:0] a);
    xfer(0, 1'b0, a, 32'h0, sq);
  endtask
  task cmd(input logic [15:0] c);
    sw(1, isl_pkg::OFS_CMD, {16'h0, c});
    do
      xfer(1, 1'b0, isl_pkg::OFS_MSTAT, 32'h0, mq);
    while (mq[0] === 1'b1);
  endtask
  task waitbit(input int b);
    do
      st(isl_pkg::OFS_STAT);
    while (sq[b] !== 1'b1);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    sw(0, isl_pkg::OFS_ADDR, 32'h54);
    sw(0, isl_pkg::OFS_ADDR2, 32'h44);
    sw(0, isl_pkg::OFS_CTRL, 32'h0);
    cmd(16'h0001);
    cmd(16'h5404);
    `CHK(mq[1], 1'b0);
    st(isl_pkg::OFS_STAT);
    `CHK(sq[9:0] & 10'h145, 10'h045);
    st(isl_pkg::OFS_RXBUF);
    `CHK(sq[7:0], 8'h54);
    st(isl_pkg::OFS_STAT);
    `CHK(sq[isl_pkg::ST_BF], 1'b0);
    sw(0, isl_pkg::OFS_STAT, 32'hFF);
    cmd(16'hA504);
    st(isl_pkg::OFS_STAT);
    `CHK(sq[isl_pkg::ST_IRQ], 1'b1);
    // buffer still full from the last byte
    cmd(16'h3C04);
    `CHK(mq[1], 1'b1);
    sw(0, isl_pkg::OFS_CTRL, 32'h20);
    // a nack ends the transfer: address again, buffer still full
    cmd(16'h0002);
    cmd(16'h0001);
    cmd(16'h5404);
    `CHK(mq[1], 1'b0);
    cmd(16'h5A04);
    `CHK(mq[1], 1'b0);
    st(isl_pkg::OFS_RXBUF);
    `CHK(sq[7:0], 8'h5A);
    cmd(16'h0002);
    st(isl_pkg::OFS_STAT);
    `CHK(sq[isl_pkg::ST_STOP], 1'b1);
    sw(0, isl_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      sw(0, isl_pkg::OFS_STAT, 32'hFF);
      cmd(16'h0001);
      cmd({adr[i], 8'h04});
      `CHK(mq[1], i == 2);
      cmd(16'h0002);
      st(isl_pkg::OFS_STAT);
      `CHK(sq[isl_pkg::ST_IRQ], i != 2);
      `CHK(sq[isl_pkg::ST_BF], i != 2);
      st(isl_pkg::OFS_RXBUF);
    end
    sw(0, isl_pkg::OFS_CTRL, {30'h0, isl_pkg::MODE_7_SP});
    sw(0, isl_pkg::OFS_STAT, 32'hFF);
    cmd(16'h0001);
    st(isl_pkg::OFS_STAT);
    `CHK(sq[isl_pkg::ST_IRQ], 1'b1);
    cmd(16'h0002);
    sw(0, isl_pkg::OFS_CTRL, 32'h1C);
    sw(0, isl_pkg::OFS_STAT, 32'hFF);
    cmd(16'h0001);
    fork
      cmd(16'h5404);
      begin
        waitbit(isl_pkg::ST_ACK_TIME_FLAG);
        `CHK(sq[isl_pkg::ST_ACK_TIME_FLAG], 1'b1);
        sw(0, isl_pkg::OFS_CTRL, 32'h9C);
      end
    join
    `CHK(mq[1], 1'b1);
    cmd(16'h0002);
    st(isl_pkg::OFS_RXBUF);
    sw(0, isl_pkg::OFS_CTRL, {30'h0, isl_pkg::MODE_10});
    sw(0, isl_pkg::OFS_ADDR, 32'h06);
    sw(0, isl_pkg::OFS_STAT, 32'hFF);
    cmd(16'h0001);
    cmd(16'hF604);
    `CHK(mq[1], 1'b0);
    fork
      cmd(16'h3504);
      begin
        waitbit(isl_pkg::ST_UA);
        st(isl_pkg::OFS_RXBUF);
        sw(0, isl_pkg::OFS_ADDR, 32'h35);
        st(isl_pkg::OFS_STAT);
        `CHK(sq[isl_pkg::ST_UA], 1'b0);
        waitbit(isl_pkg::ST_UA);
        sw(0, isl_pkg::OFS_ADDR, 32'h06);
      end
    join
    `CHK(mq[1], 1'b0);
    cmd(16'h0002);
    end_of_test;
  end
endmodule // i2c_slave_addr_ack_receive_tb_top
